/* logic/pts_pkg.sv */
// Package with constants, types and states for the processor trap sequencer.
package pts_pkg;

  // ****************************************************************
  // APB register map
  // ****************************************************************
  localparam logic [11:0] PTS_ADDR_PC = 12'h000;
  localparam logic [11:0] PTS_ADDR_PSW = 12'h004;
  localparam logic [11:0] PTS_ADDR_SP = 12'h008;
  localparam logic [11:0] PTS_ADDR_STATUS = 12'h00C;
  localparam int PTS_STAT_BUSY_BIT = 8;
  localparam int PTS_STAT_VEC_LSB = 16;

  // ****************************************************************
  // Trap vectors (octal 250, 4, 114, 14, 4, 24) and limits
  // ****************************************************************
  localparam logic [15:0] PTS_VEC_MAP = 16'h00A8;
  localparam logic [15:0] PTS_VEC_TIMEOUT = 16'h0004;
  localparam logic [15:0] PTS_VEC_PARITY = 16'h004C;
  localparam logic [15:0] PTS_VEC_TRACE = 16'h000C;
  localparam logic [15:0] PTS_VEC_STACK = 16'h0004;
  localparam logic [15:0] PTS_VEC_POWER = 16'h0014;
  localparam logic [15:0] PTS_STACK_LIMIT = 16'h0100;
  localparam logic [15:0] PTS_WORD_STEP = 16'h0002;
  localparam int PTS_TRACE_BIT = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] PTS_PC_RST = 16'h0000;
  localparam logic [15:0] PTS_PSW_RST = 16'h0000;
  localparam logic [15:0] PTS_SP_RST = 16'h1000;

  // ****************************************************************
  // Pending condition indices, highest priority first
  // ****************************************************************
  localparam int PTS_NCOND = 6;
  localparam int PTS_C_MAP = 0;
  localparam int PTS_C_TIMEOUT = 1;
  localparam int PTS_C_PARITY = 2;
  localparam int PTS_C_TRACE = 3;
  localparam int PTS_C_STACK = 4;
  localparam int PTS_C_POWER = 5;

  typedef enum logic [3:0] {
    PTS_IDLE, PTS_PUSH_PSW, PTS_PUSH_PC, PTS_FETCH_PC, PTS_FETCH_PSW,
    PTS_JSR_POP, PTS_JSR_PUSH, PTS_RTI_PC, PTS_RTI_PSW
  } pts_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pts_mem_req_t;

endpackage

/* logic/pts_trap_sequencer.sv */
// Trap arbitration, trap entry, coroutine swap and return sequencer.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.

// Overview of operation
// - Pending condition enters service, fixed vector
// - Fixed priority map, timeout, parity, trace, stack, power
// - Map violation aborts, vectors octal 250
// - Bus timeout aborts, vectors octal 4
// - Parity signal aborts, vectors octal 114
// - Trace bit at boundary traps octal 14
// - Coroutine push or APB SP write below 400 traps octal 4 after
// - Power good loss traps octal 24 after
// - No trap condition is maskable
// - Abort conditions treated as mutually exclusive
// - Coroutine call swaps PC and stack top
// - Pop target, push old PC, jump
// - Linkage pushed last-in first-out
// - Entry pushes status word then PC
// - Load PC then status from vector
// - Return pops PC then status word
module pts_trap_sequencer
  import pts_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic map_violation_abort,
  input wire logic bus_timeout_abort,
  input wire logic bus_parity_abort,
  input wire logic instr_end,
  input wire logic jump_to_subroutine_op,
  input wire logic return_from_interrupt_op,
  input wire logic bus_power_good,
  output pts_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic [15:0] program_counter,
  output logic [15:0] processor_status_word,
  output logic [15:0] stack_register,
  output logic seq_busy,
  output logic instr_abort
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pts_state_t state_reg;
  pts_mem_req_t mem_reg;
  logic [15:0] pc_reg;
  logic [15:0] psw_reg;
  logic [15:0] sp_reg;
  logic [15:0] tmp_reg;
  logic [15:0] vec_reg;
  logic [PTS_NCOND-1:0] pend_reg;
  logic [PTS_NCOND-1:0] pend_next;
  logic boundary_reg;
  logic abort_reg;
  logic busy_reg;
  logic pg_s1_reg;
  logic pg_s2_reg;
  logic pg_s3_reg;
  logic pg_stable_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [PTS_NCOND-1:0] eligible;
  logic [PTS_NCOND-1:0] win;
  logic [15:0] win_vec;
  logic take_trap;
  logic win_abort;
  logic power_fall;
  logic stack_dropped;
  logic apb_setup;
  logic apb_wr;
  logic idle;
  logic [2:0] abort_in;

  assign idle = (state_reg == PTS_IDLE);
  assign apb_setup = psel && !penable;
  // A write lands only at the edge that completes the access phase.
  assign apb_wr = psel && penable && pready_reg && pwrite;
  assign abort_in = {bus_parity_abort, bus_timeout_abort, map_violation_abort};

  // ****************************************************************
  // Power good synchroniser
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pg_s1_reg <= 1'b1;
      pg_s2_reg <= 1'b1;
      pg_s3_reg <= 1'b1;
      pg_stable_reg <= 1'b1;
    end else begin
      pg_s1_reg <= bus_power_good;
      pg_s2_reg <= pg_s1_reg;
      pg_s3_reg <= pg_s2_reg;
      if (pg_s2_reg == pg_s3_reg) begin
        pg_stable_reg <= pg_s3_reg;
      end
    end
  end

  // The supply monitor drops power good on loss; only a settled fall counts.
  assign power_fall = pg_stable_reg && !pg_s2_reg && !pg_s3_reg;

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  always_comb begin
    // Aborts are taken at once; the rest wait for an instruction boundary.
    eligible = pend_reg;
    if (!boundary_reg) begin
      eligible[PTS_C_POWER:PTS_C_TRACE] = '0;
    end
    win = eligible & PTS_NCOND'(~eligible + 1'b1);
    take_trap = idle && (|eligible);
    win_abort = |win[PTS_C_PARITY:PTS_C_MAP];
    case (win)
      6'h01: win_vec = PTS_VEC_MAP;
      6'h02: win_vec = PTS_VEC_TIMEOUT;
      6'h04: win_vec = PTS_VEC_PARITY;
      6'h08: win_vec = PTS_VEC_TRACE;
      6'h10: win_vec = PTS_VEC_STACK;
      6'h20: win_vec = PTS_VEC_POWER;
      default: win_vec = PTS_VEC_MAP;
    endcase
  end

  assign stack_dropped = (state_reg == PTS_JSR_PUSH) && !mem_reg.req
    && ((sp_reg - PTS_WORD_STEP) < PTS_STACK_LIMIT);

  // ****************************************************************
  // Pending conditions
  // ****************************************************************
  always_comb begin
    pend_next = pend_reg;
    if (take_trap) begin
      // One aborted instruction discards every abort cause.
      if (win_abort) begin
        pend_next[PTS_C_PARITY:PTS_C_MAP] = '0;
      end else begin
        pend_next = pend_reg & ~win;
      end
    end
    // A new event wins over a clear in the same cycle.
    pend_next[PTS_C_MAP] = pend_next[PTS_C_MAP] | map_violation_abort;
    pend_next[PTS_C_TIMEOUT] = pend_next[PTS_C_TIMEOUT] | bus_timeout_abort;
    pend_next[PTS_C_PARITY] = pend_next[PTS_C_PARITY] | bus_parity_abort;
    if (instr_end && psw_reg[PTS_TRACE_BIT]) begin
      pend_next[PTS_C_TRACE] = 1'b1;
    end
    if (stack_dropped) begin
      pend_next[PTS_C_STACK] = 1'b1;
    end
    if (apb_wr && idle && paddr == PTS_ADDR_SP && pwdata[15:0] < PTS_STACK_LIMIT) begin
      pend_next[PTS_C_STACK] = 1'b1;
    end
    if (power_fall) begin
      pend_next[PTS_C_POWER] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend_reg <= '0;
      boundary_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      if (instr_end) begin
        boundary_reg <= 1'b1;
      end else if (idle) begin
        boundary_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Sequencer and architectural registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= PTS_IDLE;
      mem_reg <= '0;
      pc_reg <= PTS_PC_RST;
      psw_reg <= PTS_PSW_RST;
      sp_reg <= PTS_SP_RST;
      tmp_reg <= '0;
      vec_reg <= '0;
      abort_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      abort_reg <= 1'b0;
      case (state_reg)
        PTS_IDLE: begin
          if (apb_wr && paddr == PTS_ADDR_PC) begin
            pc_reg <= pwdata[15:0];
          end
          if (apb_wr && paddr == PTS_ADDR_PSW) begin
            psw_reg <= pwdata[15:0];
          end
          if (apb_wr && paddr == PTS_ADDR_SP) begin
            sp_reg <= pwdata[15:0];
          end
          busy_reg <= 1'b0;
          if (take_trap) begin
            vec_reg <= win_vec;
            abort_reg <= win_abort;
            busy_reg <= 1'b1;
            state_reg <= PTS_PUSH_PSW;
          end else if (jump_to_subroutine_op) begin
            busy_reg <= 1'b1;
            state_reg <= PTS_JSR_POP;
          end else if (return_from_interrupt_op) begin
            busy_reg <= 1'b1;
            state_reg <= PTS_RTI_PC;
          end
        end
        PTS_PUSH_PSW: begin
          if (!mem_reg.req) begin
            sp_reg <= sp_reg - PTS_WORD_STEP;
            mem_reg <= '{req: 1'b1, we: 1'b1, addr: sp_reg - PTS_WORD_STEP, wdata: psw_reg};
          end else if (mem_ack) begin
            mem_reg.req <= 1'b0;
            state_reg <= PTS_PUSH_PC;
          end
        end
        PTS_PUSH_PC: begin
          if (!mem_reg.req) begin
            sp_reg <= sp_reg - PTS_WORD_STEP;
            mem_reg <= '{req: 1'b1, we: 1'b1, addr: sp_reg - PTS_WORD_STEP, wdata: pc_reg};
          end else if (mem_ack) begin
            mem_reg.req <= 1'b0;
            state_reg <= PTS_FETCH_PC;
          end
        end
        PTS_FETCH_PC: begin
          if (!mem_reg.req) begin
            mem_reg <= '{req: 1'b1, we: 1'b0, addr: vec_reg, wdata: '0};
          end else if (mem_ack) begin
            mem_reg.req <= 1'b0;
            pc_reg <= mem_rdata;
            state_reg <= PTS_FETCH_PSW;
          end
        end
        PTS_FETCH_PSW: begin
          if (!mem_reg.req) begin
            mem_reg <= '{req: 1'b1, we: 1'b0, addr: vec_reg + PTS_WORD_STEP, wdata: '0};
          end else if (mem_ack) begin
            mem_reg.req <= 1'b0;
            psw_reg <= mem_rdata;
            state_reg <= PTS_IDLE;
          end
        end
        PTS_JSR_POP: begin
          if (!mem_reg.req) begin
            mem_reg <= '{req: 1'b1, we: 1'b0, addr: sp_reg, wdata: '0};
          end else if (mem_ack) begin
            mem_reg.req <= 1'b0;
            tmp_reg <= mem_rdata;
            sp_reg <= sp_reg + PTS_WORD_STEP;
            state_reg <= PTS_JSR_PUSH;
          end
        end
        PTS_JSR_PUSH: begin
          if (!mem_reg.req) begin
            sp_reg <= sp_reg - PTS_WORD_STEP;
            mem_reg <= '{req: 1'b1, we: 1'b1, addr: sp_reg - PTS_WORD_STEP, wdata: pc_reg};
          end else if (mem_ack) begin
            mem_reg.req <= 1'b0;
            pc_reg <= tmp_reg;
            state_reg <= PTS_IDLE;
          end
        end
        PTS_RTI_PC: begin
          if (!mem_reg.req) begin
            mem_reg <= '{req: 1'b1, we: 1'b0, addr: sp_reg, wdata: '0};
          end else if (mem_ack) begin
            mem_reg.req <= 1'b0;
            pc_reg <= mem_rdata;
            sp_reg <= sp_reg + PTS_WORD_STEP;
            state_reg <= PTS_RTI_PSW;
          end
        end
        PTS_RTI_PSW: begin
          if (!mem_reg.req) begin
            mem_reg <= '{req: 1'b1, we: 1'b0, addr: sp_reg, wdata: '0};
          end else if (mem_ack) begin
            mem_reg.req <= 1'b0;
            psw_reg <= mem_rdata;
            sp_reg <= sp_reg + PTS_WORD_STEP;
            state_reg <= PTS_IDLE;
          end
        end
        default: begin
          mem_reg <= '0;
          state_reg <= PTS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= apb_setup;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      if (apb_setup) begin
        case (paddr)
          PTS_ADDR_PC: prdata_reg <= {16'h0000, pc_reg};
          PTS_ADDR_PSW: prdata_reg <= {16'h0000, psw_reg};
          PTS_ADDR_SP: prdata_reg <= {16'h0000, sp_reg};
          PTS_ADDR_STATUS: begin
            prdata_reg[PTS_NCOND-1:0] <= pend_reg;
            prdata_reg[PTS_STAT_BUSY_BIT] <= busy_reg;
            prdata_reg[PTS_STAT_VEC_LSB +: 16] <= vec_reg;
          end
          default: pslverr_reg <= 1'b1;
        endcase
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mem_req = mem_reg;
  assign program_counter = pc_reg;
  assign processor_status_word = psw_reg;
  assign stack_register = sp_reg;
  assign seq_busy = busy_reg;
  assign instr_abort = abort_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_map_vec;
    take_trap && pend_reg[PTS_C_MAP] |=> vec_reg == PTS_VEC_MAP && abort_reg;
  endproperty
  a_map_vec: assert property (p_map_vec) else $error("map abort vector wrong");

  property p_timeout_vec;
    take_trap && win[PTS_C_TIMEOUT] |=> vec_reg == PTS_VEC_TIMEOUT && abort_reg;
  endproperty
  a_timeout_vec: assert property (p_timeout_vec) else $error("timeout vector wrong");

  property p_parity_vec;
    take_trap && win[PTS_C_PARITY] |=> vec_reg == PTS_VEC_PARITY && abort_reg;
  endproperty
  a_parity_vec: assert property (p_parity_vec) else $error("parity vector wrong");

  property p_trace_set;
    instr_end && psw_reg[PTS_TRACE_BIT] |=> pend_reg[PTS_C_TRACE];
  endproperty
  a_trace_set: assert property (p_trace_set) else $error("trace not pending");

  property p_power_set;
    power_fall |=> pend_reg[PTS_C_POWER];
  endproperty
  a_power_set: assert property (p_power_set) else $error("power loss not pending");

  property p_nonmask;
    idle && boundary_reg && (|pend_reg) |=> state_reg == PTS_PUSH_PSW;
  endproperty
  a_nonmask: assert property (p_nonmask) else $error("pending trap not taken");

  property p_excl;
    take_trap && win_abort && !(|abort_in) |=> pend_reg[PTS_C_PARITY:PTS_C_MAP] == '0;
  endproperty
  a_excl: assert property (p_excl) else $error("abort causes left pending");

  property p_push_order;
    state_reg == PTS_PUSH_PSW && mem_reg.req && mem_ack
      |=> state_reg == PTS_PUSH_PC ##1 mem_reg.req && mem_reg.wdata == pc_reg;
  endproperty
  a_push_order: assert property (p_push_order) else $error("entry push order wrong");

  property p_jsr_swap;
    state_reg == PTS_JSR_PUSH && mem_reg.req && mem_ack |=> pc_reg == $past(tmp_reg);
  endproperty
  a_jsr_swap: assert property (p_jsr_swap) else $error("coroutine target not loaded");

  property p_rti_pc;
    state_reg == PTS_RTI_PC && mem_reg.req && mem_ack
      |=> pc_reg == $past(mem_rdata) && sp_reg == $past(sp_reg) + PTS_WORD_STEP;
  endproperty
  a_rti_pc: assert property (p_rti_pc) else $error("return pop wrong");

  property p_keep_low;
    take_trap && win_abort && pend_reg[PTS_C_POWER] |=> pend_reg[PTS_C_POWER];
  endproperty
  a_keep_low: assert property (p_keep_low) else $error("lower condition lost");

  c_abort_entry: cover property (take_trap && win_abort);
  c_jsr_swap: cover property (state_reg == PTS_JSR_PUSH && mem_ack);
  c_rti: cover property (state_reg == PTS_RTI_PSW && mem_ack);
  c_two_pending: cover property (take_trap && pend_reg[PTS_C_TRACE] && pend_reg[PTS_C_POWER]);

endmodule // pts_trap_sequencer

/* dv/pts_mem_model.sv */
// Behavioural memory on the far side of the sequencer's memory port.
module pts_mem_model
  import pts_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input pts_mem_req_t mem_req,
  input wire logic slow,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [0:4095];
  int wait_cnt;

  // Outside an answer the data lines toggle so that no stale word looks valid.
  always @(posedge mclk) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_cnt <= 0;
      mem_rdata <= 16'hA5A5;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req.req) begin
      if (slow && wait_cnt < 3) begin
        wait_cnt <= wait_cnt + 1;
        mem_rdata <= ~mem_rdata;
      end else begin
        wait_cnt <= 0;
        mem_ack <= 1'b1;
        if (mem_req.we) begin
          mem[mem_req.addr[12:1]] <= mem_req.wdata;
          mem_rdata <= ~mem_rdata;
        end else begin
          mem_rdata <= mem[mem_req.addr[12:1]];
        end
      end
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // pts_mem_model

/* dv/tb_processor_trap_sequencer.sv */
// Self-checking bench for the processor trap sequencer.
module tb_processor_trap_sequencer;
  import pts_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, mem_ack, seq_busy, instr_abort;
  logic slow = 1'b0;
  logic power_good = 1'b1;
  logic [5:0] evt = 6'h00;
  logic [15:0] mem_rdata, program_counter, processor_status_word, stack_register;
  pts_mem_req_t mem_req;
  int n_fail = 0;
  int comparisons = 0;
  int n_abort = 0;
  logic [15:0] vpc [6];
  logic [15:0] vps [6];
  logic [15:0] vadr [6] = '{PTS_VEC_MAP, PTS_VEC_TIMEOUT, PTS_VEC_PARITY, PTS_VEC_TRACE,
                            PTS_VEC_STACK, PTS_VEC_POWER};
  logic [15:0] q_pc [$];
  logic [15:0] q_ps [$];
  logic [15:0] q_sp [$];

  always #25 mclk = ~mclk;
  always @(posedge mclk) if (instr_abort === 1'b1) n_abort++;

  pts_trap_sequencer uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .map_violation_abort(evt[0]), .bus_timeout_abort(evt[1]),
    .bus_parity_abort(evt[2]), .instr_end(evt[3]), .jump_to_subroutine_op(evt[4]),
    .return_from_interrupt_op(evt[5]), .bus_power_good(power_good), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .program_counter(program_counter),
    .processor_status_word(processor_status_word), .stack_register(stack_register),
    .seq_busy(seq_busy), .instr_abort(instr_abort));

  pts_mem_model u_mem (.mclk(mclk), .rst_n(rst_n), .mem_req(mem_req), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {16'h0000, d}, q, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q[15:0], exp[15:0]);
    chk(q[31:16], exp[31:16]);
    chk({15'h0000, e}, {15'h0000, experr});
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge mclk);
    evt <= m;
    @(posedge mclk);
    evt <= 6'h00;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge mclk);
    while (seq_busy !== 1'b0 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 300) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic arm();
    @(posedge mclk);
    q_pc.push_back(program_counter);
    q_ps.push_back(processor_status_word);
    q_sp.push_back(stack_register);
  endtask

  task automatic entry(input int c);
    logic [15:0] sp0;
    sp0 = q_sp[$];
    wait_idle();
    chk(program_counter, vpc[c]);
    chk(processor_status_word, vps[c]);
    chk(stack_register, sp0 - 16'h0004);
    chk(u_mem.mem[(sp0 - 16'h0002) >> 1], q_ps[$]);
    chk(u_mem.mem[(sp0 - 16'h0004) >> 1], q_pc[$]);
  endtask

  task automatic rti_chk();
    pulse(6'h20);
    wait_idle();
    chk(program_counter, q_pc.pop_back());
    chk(processor_status_word, q_ps.pop_back());
    chk(stack_register, q_sp.pop_back());
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [15:0] t;
    logic [15:0] pc0;
    int k;
    int a0;
    void'($urandom(18625));
    for (k = 0; k < 6; k++) begin
      vpc[k] = 16'($urandom) & 16'hFFFE;
      vps[k] = 16'($urandom) & 16'hFFEF;
      u_mem.mem[vadr[k] >> 1] = vpc[k];
      u_mem.mem[(vadr[k] >> 1) + 1] = vps[k];
    end
    vpc[1] = vpc[4];
    vps[1] = vps[4];
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(PTS_ADDR_PC, {16'h0000, PTS_PC_RST}, 1'b0);
    rd_chk(PTS_ADDR_SP, {16'h0000, PTS_SP_RST}, 1'b0);
    rd_chk(12'h010, 32'h0000_0000, 1'b1);
    // Each abort alone, with priority bits raised and slow or fast memory.
    for (k = 0; k < 6; k++) begin
      slow <= k[0];
      wr(PTS_ADDR_SP, 16'h1000);
      wr(PTS_ADDR_PSW, (16'($urandom) | 16'h00E0) & 16'hFFEF);
      wr(PTS_ADDR_PC, 16'($urandom) & 16'hFFFE);
      arm();
      a0 = n_abort;
      pulse(6'h01 << (k % 3));
      entry(k % 3);
      chk(16'(n_abort - a0), 16'h0001);
      rd_chk(PTS_ADDR_STATUS, {vadr[k % 3], 16'h0000}, 1'b0);
      rti_chk();
    end
    arm();
    pulse(6'h07);
    entry(0);
    rd_chk(PTS_ADDR_STATUS, {PTS_VEC_MAP, 16'h0000}, 1'b0);
    rti_chk();
    // Trace, stack low and power loss pending together, taken one by one.
    wr(PTS_ADDR_PSW, 16'h00F0);
    wr(PTS_ADDR_SP, 16'h00F0);
    power_good <= 1'b0;
    repeat (6) @(posedge mclk);
    a0 = n_abort;
    arm();
    pulse(6'h08);
    entry(3);
    rd_chk(PTS_ADDR_STATUS, {PTS_VEC_TRACE, 16'h0030}, 1'b0);
    arm();
    pulse(6'h08);
    entry(4);
    arm();
    pulse(6'h08);
    entry(5);
    chk(16'(n_abort - a0), 16'h0000);
    power_good <= 1'b1;
    repeat (3) rti_chk();
    // Coroutine swap there and back.
    wr(PTS_ADDR_SP, 16'h0800);
    t = 16'($urandom) & 16'hFFFE;
    u_mem.mem[16'h0400] = t;
    pc0 = program_counter;
    pulse(6'h10);
    wait_idle();
    chk(program_counter, t);
    chk(stack_register, 16'h0800);
    chk(u_mem.mem[16'h0400], pc0);
    pulse(6'h10);
    wait_idle();
    chk(program_counter, pc0);
    chk(u_mem.mem[16'h0400], t);
    close_out();
  end
endmodule // tb_processor_trap_sequencer
